// [core/adc_seq_cfg.svh]
// Register map, field positions, reset values and timing counts of the conversion sequencer.
`ifndef ADC_SEQ_CFG_SVH
`define ADC_SEQ_CFG_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define OFS_CONTROL      8'h00
`define OFS_RESULT       8'h04
`define OFS_IRQ_STATUS   8'h08
`define OFS_IRQ_MASK     8'h0c
`define OFS_GLOBAL_IRQ   8'h10
`define OFS_SEQ_STATE    8'h14

// ----------------------------------------------------------------------
// Control register fields, and the done bit of the interrupt status and mask registers
// ----------------------------------------------------------------------
`define FLD_ON           0
`define FLD_GO           2
`define FLD_CHAN_LO      3
`define FLD_CHAN_HI      5
`define FLD_CLK_LO       6
`define FLD_CLK_HI       7
`define FLD_DONE         0

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RST_CONTROL      8'h00
`define RST_RESULT       8'h00

// ----------------------------------------------------------------------
// Conversion clock selection and timing
// ----------------------------------------------------------------------
`define CLK_FOSC2        2'h0
`define CLK_FOSC8        2'h1
`define CLK_FOSC32       2'h2
`define CLK_RC           2'h3
`define DIV_FOSC2        8'h02
`define DIV_FOSC8        8'h08
`define DIV_FOSC32       8'h20
`define MIN_BIT_CYCLES   8'h03
`define MCLK_PERIOD_NS   20
`define RC_BIT_PERIOD_NS 4000
`define RC_BIT_CYCLES    ((`RC_BIT_PERIOD_NS + `MCLK_PERIOD_NS - 1) / `MCLK_PERIOD_NS)
`define ABORT_WAIT_BITS  2'h2

`endif

// [core/adc_seq_pkg.sv]
// Types shared by the conversion sequencer.
`default_nettype none
package adc_seq_pkg;
   typedef enum logic [1:0] {S_OFF, S_ACQ, S_CONV, S_ABORT} seq_state_t;
endpackage
`default_nettype wire

// [core/adc_conversion_sequencer.sv]
// Successive-approximation conversion sequencer with an APB register file.
//
// Chosen here: register access over APB and the register addresses.
`include "adc_seq_cfg.svh"
`default_nettype none

// What this block does
// - Clearing go during a conversion stops it at once; a write in the cycle of the last bit decision still completes it.
// - An aborted conversion leaves the result register unchanged.
// - After an abort, no acquisition starts for two conversion bit periods.
// - After that wait, acquisition starts alone on the selected channel.
// - A finished conversion sets the done flag and clears go.
// - Control value c1 selects RC clock, converter on, channel zero.
module adc_conversion_sequencer (
   input  wire logic        MCLK,
   input  wire logic        RESET,
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [7:0]  PADDR,
   input  wire logic [31:0] PWDATA,
   output var  logic [31:0] PRDATA,
   output var  logic        PREADY,
   output var  logic        PSLVERR,
   input  wire logic        COMP_IN,
   output var  logic        SAMPLE_HOLD,
   output var  logic [2:0]  CHANNEL_SELECT,
   output var  logic [7:0]  DAC_CODE,
   output var  logic        IRQ
);

   // ----------------------------------------------------------------------
   // State
   // ----------------------------------------------------------------------
   adc_seq_pkg::seq_state_t state_r, state_nxt;
   logic [1:0]  clk_sel_r, clk_sel_nxt;
   logic [2:0]  chan_r, chan_nxt;
   logic        on_r, on_nxt;
   logic        go_r, go_nxt;
   logic [7:0]  result_r, result_nxt;
   logic        stat_r, stat_nxt;
   logic        irq_en_r, irq_en_nxt;
   logic        gie_r, gie_nxt;
   logic [7:0]  div_cnt_r, div_cnt_nxt;
   logic [1:0]  abort_ticks_r, abort_ticks_nxt;
   logic [2:0]  bit_r, bit_nxt;
   logic [7:0]  sar_r, sar_nxt;
   logic [31:0] prdata_r, prdata_nxt;
   logic        pready_r, pready_nxt;
   logic        pslverr_r, pslverr_nxt;
   logic        sample_r, sample_nxt;
   logic        irq_r, irq_nxt;
   logic        comp_s1_r, comp_s2_r;
   logic [15:0] abort_len_r, abort_len_nxt;
   logic [7:0]  tad_div;
   logic        tad_tick;
   logic        wr_en;
   logic        done_evt;

   assign PRDATA         = prdata_r;
   assign PREADY         = pready_r;
   assign PSLVERR        = pslverr_r;
   assign SAMPLE_HOLD    = sample_r;
   assign CHANNEL_SELECT = chan_r;
   assign DAC_CODE       = sar_r;
   assign IRQ            = irq_r;

   // ----------------------------------------------------------------------
   // Comparator synchroniser
   // ----------------------------------------------------------------------
   always_ff @(posedge MCLK or posedge RESET) begin
      if (RESET) begin
         comp_s1_r <= 1'b0;
         comp_s2_r <= 1'b0;
      end else begin
         comp_s1_r <= COMP_IN;
         comp_s2_r <= comp_s1_r;
      end
   end

   // ----------------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------------
   always_comb begin
      state_nxt       = state_r;
      clk_sel_nxt     = clk_sel_r;
      chan_nxt        = chan_r;
      on_nxt          = on_r;
      go_nxt          = go_r;
      result_nxt      = result_r;
      irq_en_nxt      = irq_en_r;
      gie_nxt         = gie_r;
      abort_ticks_nxt = abort_ticks_r;
      bit_nxt         = bit_r;
      sar_nxt         = sar_r;
      abort_len_nxt   = 16'h0000;
      done_evt        = 1'b0;
      wr_en           = PSEL & PENABLE & pready_r & PWRITE;
      case (clk_sel_r)
         // The synchronised comparator needs three cycles to reflect a new trial code.
         `CLK_FOSC2:  tad_div = (`DIV_FOSC2 < `MIN_BIT_CYCLES) ? `MIN_BIT_CYCLES : `DIV_FOSC2;
         `CLK_FOSC8:  tad_div = `DIV_FOSC8;
         `CLK_FOSC32: tad_div = `DIV_FOSC32;
         default:     tad_div = 8'(`RC_BIT_CYCLES);
      endcase
      tad_tick    = (div_cnt_r == 8'(tad_div - 8'h01));
      div_cnt_nxt = tad_tick ? 8'h00 : 8'(div_cnt_r + 8'h01);

      // Software register writes.
      if (wr_en && PADDR == `OFS_CONTROL) begin
         clk_sel_nxt = PWDATA[`FLD_CLK_HI:`FLD_CLK_LO];
         chan_nxt    = PWDATA[`FLD_CHAN_HI:`FLD_CHAN_LO];
         on_nxt      = PWDATA[`FLD_ON];
         // Go only starts from an already running converter.
         if (!PWDATA[`FLD_GO] || !PWDATA[`FLD_ON]) begin
            go_nxt = 1'b0;
         end else if (on_r && state_r != adc_seq_pkg::S_ABORT) begin
            go_nxt = 1'b1;
         end
      end
      if (wr_en && PADDR == `OFS_RESULT) begin
         result_nxt = PWDATA[7:0];
      end
      if (wr_en && PADDR == `OFS_IRQ_MASK) begin
         irq_en_nxt = PWDATA[`FLD_DONE];
      end
      if (wr_en && PADDR == `OFS_GLOBAL_IRQ) begin
         gie_nxt = PWDATA[0];
      end

      // Sequencer.
      case (state_r)
         adc_seq_pkg::S_OFF: begin
            go_nxt = 1'b0;
            if (on_r) begin
               state_nxt = adc_seq_pkg::S_ACQ;
            end
         end
         adc_seq_pkg::S_ACQ: begin
            if (!on_r) begin
               state_nxt = adc_seq_pkg::S_OFF;
            end else if (go_r) begin
               state_nxt   = adc_seq_pkg::S_CONV;
               div_cnt_nxt = 8'h00;
               bit_nxt     = 3'h7;
               sar_nxt     = 8'h80;
            end
         end
         adc_seq_pkg::S_CONV: begin
            if (!on_r) begin
               state_nxt = adc_seq_pkg::S_OFF;
            end else if (!go_r) begin
               state_nxt       = adc_seq_pkg::S_ABORT;
               div_cnt_nxt     = 8'h00;
               abort_ticks_nxt = 2'h0;
            end else if (tad_tick) begin
               sar_nxt[bit_r] = comp_s2_r;
               if (bit_r == 3'h0) begin
                  result_nxt = {sar_r[7:1], comp_s2_r};
                  done_evt   = 1'b1;
                  go_nxt     = 1'b0;
                  state_nxt  = adc_seq_pkg::S_ACQ;
               end else begin
                  sar_nxt[3'(bit_r - 3'h1)] = 1'b1;
                  bit_nxt = 3'(bit_r - 3'h1);
               end
            end
         end
         adc_seq_pkg::S_ABORT: begin
            abort_len_nxt = 16'(abort_len_r + 16'h0001);
            if (!on_r) begin
               state_nxt = adc_seq_pkg::S_OFF;
            end else if (tad_tick) begin
               abort_ticks_nxt = 2'(abort_ticks_r + 2'h1);
               if (2'(abort_ticks_r + 2'h1) == `ABORT_WAIT_BITS) begin
                  state_nxt = adc_seq_pkg::S_ACQ;
               end
            end
         end
         default: begin
            state_nxt = adc_seq_pkg::S_OFF;
         end
      endcase

      // Done flag: a completion in the clearing cycle wins.
      stat_nxt = (stat_r & ~(wr_en && PADDR == `OFS_IRQ_STATUS && PWDATA[`FLD_DONE]))
                 | done_evt;
      irq_nxt    = stat_r & irq_en_r & gie_r;
      sample_nxt = (state_nxt == adc_seq_pkg::S_ACQ);

      // APB setup cycle latches the answer; access cycle shows it.
      pready_nxt  = PSEL & ~PENABLE & ~pready_r;
      pslverr_nxt = 1'b0;
      prdata_nxt  = 32'h0000_0000;
      if (PSEL && !PENABLE) begin
         case (PADDR)
            `OFS_CONTROL:    prdata_nxt = {24'h0, clk_sel_r, chan_r, go_r, 1'b0, on_r};
            `OFS_RESULT:     prdata_nxt = {24'h0, result_r};
            `OFS_IRQ_STATUS: prdata_nxt = {31'h0, stat_r};
            `OFS_IRQ_MASK:   prdata_nxt = {31'h0, irq_en_r};
            `OFS_GLOBAL_IRQ: prdata_nxt = {31'h0, gie_r};
            `OFS_SEQ_STATE:  prdata_nxt = {27'h0, bit_r, state_r};
            default:         pslverr_nxt = 1'b1;
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------------
   always_ff @(posedge MCLK or posedge RESET) begin
      if (RESET) begin
         state_r       <= adc_seq_pkg::S_OFF;
         clk_sel_r     <= 2'(`RST_CONTROL >> `FLD_CLK_LO);
         chan_r        <= 3'h0;
         on_r          <= 1'b0;
         go_r          <= 1'b0;
         result_r      <= `RST_RESULT;
         stat_r        <= 1'b0;
         irq_en_r      <= 1'b0;
         gie_r         <= 1'b0;
         div_cnt_r     <= 8'h00;
         abort_ticks_r <= 2'h0;
         bit_r         <= 3'h0;
         sar_r         <= 8'h00;
         prdata_r      <= 32'h0000_0000;
         pready_r      <= 1'b0;
         pslverr_r     <= 1'b0;
         sample_r      <= 1'b0;
         irq_r         <= 1'b0;
         abort_len_r   <= 16'h0000;
      end else begin
         state_r       <= state_nxt;
         clk_sel_r     <= clk_sel_nxt;
         chan_r        <= chan_nxt;
         on_r          <= on_nxt;
         go_r          <= go_nxt;
         result_r      <= result_nxt;
         stat_r        <= stat_nxt;
         irq_en_r      <= irq_en_nxt;
         gie_r         <= gie_nxt;
         div_cnt_r     <= div_cnt_nxt;
         abort_ticks_r <= abort_ticks_nxt;
         bit_r         <= bit_nxt;
         sar_r         <= sar_nxt;
         prdata_r      <= prdata_nxt;
         pready_r      <= pready_nxt;
         pslverr_r     <= pslverr_nxt;
         sample_r      <= sample_nxt;
         irq_r         <= irq_nxt;
         abort_len_r   <= abort_len_nxt;
      end
   end

   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (RESET);

   AST_ABORT_STOPS: assert property (
      (state_r == adc_seq_pkg::S_CONV && !go_r && on_r)
      |=> state_r == adc_seq_pkg::S_ABORT && (!stat_r || $past(stat_r)))
      else $error("Cleared go did not abort the conversion.");

   AST_ABORT_KEEPS_RESULT: assert property (
      (state_nxt == adc_seq_pkg::S_ABORT && !(wr_en && PADDR == `OFS_RESULT))
      |=> $stable(result_r))
      else $error("Result changed during an abort.");

   AST_ABORT_WAIT_LEN: assert property (
      (state_r == adc_seq_pkg::S_ABORT && state_nxt == adc_seq_pkg::S_ACQ)
      |-> abort_len_r == 16'(2 * tad_div - 1))
      else $error("Post-abort wait was not two bit periods.");

   AST_ABORT_REACQUIRE: assert property (
      ($past(state_r) == adc_seq_pkg::S_ABORT && state_r != adc_seq_pkg::S_ABORT && on_r)
      |-> state_r == adc_seq_pkg::S_ACQ ##1 SAMPLE_HOLD && CHANNEL_SELECT == chan_r)
      else $error("No automatic acquisition after the abort wait.");

   AST_DONE_FLAG: assert property (
      (state_r == adc_seq_pkg::S_CONV && on_r && go_r && tad_tick && bit_r == 3'h0)
      |=> stat_r && !go_r && state_r == adc_seq_pkg::S_ACQ)
      else $error("Completion did not set done and clear go.");

   AST_CONTROL_C1: assert property (
      (wr_en && PADDR == `OFS_CONTROL && PWDATA[7:0] == 8'hc1)
      |=> clk_sel_r == `CLK_RC && on_r && chan_r == 3'h0)
      else $error("Control value c1 not decoded.");

   AST_IRQ_GATING: assert property (
      IRQ |-> $past(stat_r) && $past(irq_en_r) && $past(gie_r))
      else $error("Interrupt without flag and both enables.");

   COV_COMPLETE: cover property (done_evt);
   COV_ABORT: cover property (state_r == adc_seq_pkg::S_ABORT ##1 state_r == adc_seq_pkg::S_ACQ);
   COV_IRQ: cover property ($rose(IRQ));

endmodule

`default_nettype wire

// [verif/adc_front_model.sv]
// Behavioural analog front end: channel levels, sample-and-hold and comparator.
`default_nettype none

// ----------------------------------------------------------------------
// Analog side model
// ----------------------------------------------------------------------
module adc_front_model (
   input  wire logic            mclk,
   input  wire logic            sample_hold,
   input  wire logic [2:0]      channel_select,
   input  wire logic [7:0]      dac_code,
   input  wire logic [7:0][7:0] levels,
   output var  logic            comp_in
);
   timeunit 1ns;
   timeprecision 1ns;

   logic [7:0] held = 8'h00;

   // The hold capacitor follows the selected channel only while sampling.
   always @(posedge mclk) begin
      if (sample_hold) begin
         held <= levels[channel_select];
      end
   end

   // The comparator is high while the held input is at or above the trial code.
   always_comb begin
      comp_in = (held >= dac_code);
   end
endmodule
`default_nettype wire

// [verif/test_adc_conversion_sequencer.sv]
// Self-checking bench of the conversion sequencer with random and corner conversions.
`include "adc_seq_cfg.svh"
`default_nettype none
`define CHECK(what, exp, got) begin checks_done++; if ((got) !== (exp)) begin errors++; \
   $display("wrong value %s expected %0h seen %0h", what, exp, got); end end

module test_adc_conversion_sequencer;
   timeunit 1ns;
   timeprecision 1ns;

   // ----------------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------------
   logic            MCLK, RESET, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
   logic            COMP_IN, SAMPLE_HOLD, IRQ, er;
   logic [7:0]      PADDR, DAC_CODE, ref_val, lvl;
   logic [31:0]     PWDATA, PRDATA, rd;
   logic [2:0]      CHANNEL_SELECT;
   logic [7:0][7:0] levels;
   logic [15:0]     seed;
   int              errors, checks_done, n;

   adc_conversion_sequencer adc_conversion_sequencer_inst (.MCLK(MCLK), .RESET(RESET),
      .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
      .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .COMP_IN(COMP_IN),
      .SAMPLE_HOLD(SAMPLE_HOLD), .CHANNEL_SELECT(CHANNEL_SELECT), .DAC_CODE(DAC_CODE),
      .IRQ(IRQ));
   adc_front_model adc_front_model_inst (.mclk(MCLK), .sample_hold(SAMPLE_HOLD),
      .channel_select(CHANNEL_SELECT), .dac_code(DAC_CODE), .levels(levels),
      .comp_in(COMP_IN));

   // ----------------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------------
   function logic [15:0] lfsr_next(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   function logic [7:0] sar_expect(input logic [7:0] v);
      logic [7:0] code;
      code = 8'h00;
      for (int b = 7; b >= 0; b--) begin
         if (v >= (code | (8'h01 << b))) code = code | (8'h01 << b);
      end
      return code;
   endfunction

   function logic [31:0] ctl(input logic [1:0] c, input logic [2:0] ch, input logic go);
      return {24'h000000, c, ch, go, 1'b0, 1'b1};
   endfunction

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
      @(posedge MCLK);
      PSEL <= 1'b1;
      PENABLE <= 1'b0;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge MCLK);
      PENABLE <= 1'b1;
      do begin
         @(posedge MCLK);
      end while (PREADY !== 1'b1);
      q = PRDATA;
      e = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic        e;
      apb(1'b1, a, d, q, e);
   endtask

   // Starts a conversion after the sampling time and waits for its done flag.
   task automatic conv(input logic [1:0] c, input logic [2:0] ch, input logic [7:0] v);
      levels[ch] <= v;
      wr(`OFS_CONTROL, ctl(c, ch, 1'b0));
      repeat (20) @(posedge MCLK);
      wr(`OFS_CONTROL, ctl(c, ch, 1'b1));
      n = 0;
      do begin
         apb(1'b0, `OFS_IRQ_STATUS, 32'h0, rd, er);
         n++;
      end while (rd[`FLD_DONE] !== 1'b1 && n < 3000);
      `CHECK("done flag", 1'b1, rd[`FLD_DONE])
      apb(1'b0, `OFS_RESULT, 32'h0, rd, er);
      `CHECK("result", {24'h0, sar_expect(v)}, rd)
      apb(1'b0, `OFS_CONTROL, 32'h0, rd, er);
      `CHECK("go bit", 1'b0, rd[`FLD_GO])
   endtask

   task automatic irq_is(input logic exp);
      repeat (2) @(posedge MCLK);
      `CHECK("irq", exp, IRQ)
   endtask

   task conclude;
      $display("errors %0d checks %0d", errors, checks_done);
      if (errors == 0 && checks_done > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   // ----------------------------------------------------------------------
   // Clock, watchdog and test sequence
   // ----------------------------------------------------------------------
   initial begin
      MCLK = 1'b0;
      forever #10 MCLK = ~MCLK;
   end

   initial begin
      #(20 * 60000);
      errors++;
      conclude();
   end

   initial begin
      {PSEL, PENABLE, PWRITE, PADDR, PWDATA} = '0;
      levels = '0;
      errors = 0;
      checks_done = 0;
      seed = 16'hf53a;
      RESET = 1'b1;
      repeat (5) @(posedge MCLK);
      RESET <= 1'b0;
      apb(1'b0, `OFS_CONTROL, 32'h0, rd, er);
      `CHECK("control reset", {24'h0, `RST_CONTROL}, rd)
      apb(1'b0, `OFS_RESULT, 32'h0, rd, er);
      `CHECK("result reset", {24'h0, `RST_RESULT}, rd)
      apb(1'b0, 8'h18, 32'h0, rd, er);
      `CHECK("unmapped error", 1'b1, er)
      `CHECK("unmapped data", 32'h0, rd)
      wr(`OFS_CONTROL, 32'h05);
      repeat (4) @(posedge MCLK);
      apb(1'b0, `OFS_SEQ_STATE, 32'h0, rd, er);
      `CHECK("go with turn on", 2'h1, rd[1:0])
      wr(`OFS_CONTROL, 32'h00);
      wr(`OFS_CONTROL, 32'hc1);
      apb(1'b0, `OFS_CONTROL, 32'h0, rd, er);
      `CHECK("control c1", 32'hc1, rd)
      apb(1'b0, `OFS_SEQ_STATE, 32'h0, rd, er);
      `CHECK("state after c1", 5'h01, rd[4:0])
      `CHECK("sampling", 1'b1, SAMPLE_HOLD)
      `CHECK("channel", 3'h0, CHANNEL_SELECT)
      wr(`OFS_GLOBAL_IRQ, 32'h1);
      seed = lfsr_next(seed);
      conv(`CLK_RC, 3'h0, seed[7:0]);
      irq_is(1'b0);
      wr(`OFS_IRQ_MASK, 32'h1);
      irq_is(1'b1);
      wr(`OFS_GLOBAL_IRQ, 32'h0);
      irq_is(1'b0);
      wr(`OFS_GLOBAL_IRQ, 32'h1);
      irq_is(1'b1);
      wr(`OFS_IRQ_STATUS, 32'h1);
      irq_is(1'b0);
      for (int i = 0; i < 6; i++) begin
         seed = lfsr_next(seed);
         lvl = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : seed[15:8];
         conv(seed[1:0], seed[4:2], lvl);
         wr(`OFS_IRQ_STATUS, 32'h1);
      end
      seed = lfsr_next(seed);
      ref_val = seed[7:0];
      wr(`OFS_RESULT, {24'h0, ref_val});
      levels[5] <= ~ref_val;
      wr(`OFS_CONTROL, ctl(`CLK_FOSC32, 3'h5, 1'b0));
      repeat (20) @(posedge MCLK);
      wr(`OFS_CONTROL, ctl(`CLK_FOSC32, 3'h5, 1'b1));
      repeat (50) @(posedge MCLK);
      wr(`OFS_CONTROL, ctl(`CLK_FOSC32, 3'h5, 1'b0));
      n = 0;
      while (SAMPLE_HOLD !== 1'b1 && n < 1000) begin
         @(posedge MCLK);
         n++;
      end
      `CHECK("abort wait", 1'b1, (n >= 2 * `DIV_FOSC32 && n <= 2 * `DIV_FOSC32 + 2))
      `CHECK("channel after abort", 3'h5, CHANNEL_SELECT)
      apb(1'b0, `OFS_RESULT, 32'h0, rd, er);
      `CHECK("result after abort", {24'h0, ref_val}, rd)
      apb(1'b0, `OFS_IRQ_STATUS, 32'h0, rd, er);
      `CHECK("done after abort", 1'b0, rd[`FLD_DONE])
      conv(`CLK_FOSC8, 3'h5, 8'h5a);
      conclude();
   end
endmodule
`default_nettype wire
